// ### mio_core.sv
// output-control logic for pass-through and overload-relay functions
// assumes overload, warning and current come from an external thermal model
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// R01: pass-through acts as plain IO with overload
// R02: outputs follow bus, inputs reported always
// R03: configured fault output driven by device
// R04: master switches contactor itself in pass-through
// R05: no checkback, own start, busfault, dip
// R06: multifunction simulation and stop ignored
// R07: overload relay: out2, aux, inputs pass
// R08: overload relay fault output owned by device
// R09: after power-up contact zero closed, one open; code holds this only in reset, then default pass-through follows the bus bits
// R10: fault opens zero, closes one, fault output
// R11: fault sets summary fault monitoring bit
// R12: fault lights red lamp, blinks panel symbol
// R13: command bits overridden when fault output
// R14: standard bit allocation, custom may remap
// R15: emergency rising resets thermal, level suppresses inputs
// R16: monitoring word layout and current word
// R17: command word layout
module mio_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// fieldbus process image
	input wire logic [15:0] cmd_word0,
	output mio_pkg::mio_image_t mon_image,
	// thermal model and fault inputs
	input wire logic overload_trip,
	input wire logic overload_warn,
	input wire logic [15:0] motor_current_pct,
	input wire logic di_fault,
	output logic thermal_cold_reset,
	// field pins
	input wire logic digital_input_zero,
	input wire logic digital_input_one,
	input wire logic digital_input_two,
	input wire logic digital_input_three,
	input wire logic digital_input_four,
	input wire logic digital_input_five,
	output logic relay_output_zero,
	output logic relay_output_one,
	output logic relay_output_two,
	output logic aux_supply_output,
	// indicators
	output logic red_led,
	output logic panel_fault_symbol,
	// software register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// interrupt
	output logic irq
);
	import mio_pkg::*;

	// state record and its next value
	mio_state_t s_q;
	mio_state_t s_d;

	// register store read side
	logic [31:0] store_rdata;
	logic store_wr;
	logic rd_store_q;

	// decoded configuration and per-cycle events
	mio_mode_t mode;
	mio_fout_t fout;
	logic fault_in;
	logic [MIO_IRQ_W-1:0] ev;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// map a register index to the store slot
	function automatic logic [1:0] store_slot(input logic [3:0] a);
		return a[1:0];
	endfunction

	// a selected fault output follows the fault, otherwise the bus bit
	function automatic logic owned_bit(input mio_fout_t sel, input mio_fout_t pin, input logic bus_bit,
		input logic fault_now);
		logic res;
		res = bus_bit;
		if (sel == pin) begin
			res = fault_now;
		end
		return res;
	endfunction

	// blink timer step
	function automatic logic [31:0] step32(input logic [31:0] v);
		return v + 32'd1;
	endfunction

	// current clamped to the reportable range
	function automatic logic [15:0] clamp_pct(input logic [15:0] v);
		logic [15:0] res;
		res = v;
		if (v > MIO_CURRENT_MAX) begin
			res = MIO_CURRENT_MAX;
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// auxiliary store for blink period
	// ----------------------------------------------------------------
	mio_regfile #(
		.DEPTH(4),
		.WIDTH(32)
	) u_store (
		.ref_clk(ref_clk),
		.reset(reset),
		.wr_en(store_wr),
		.wr_addr(store_slot(reg_addr)),
		.wr_data(reg_wdata),
		.rd_addr(store_slot(MIO_REG_BLINK)),
		.rd_data(store_rdata)
	);

	// store written only at the blink period index
	assign store_wr = reg_wr && reg_addr == MIO_REG_BLINK;

	// decoded config
	assign mode = mio_mode_t'(s_q.cfg[0]);
	assign fout = mio_fout_t'(s_q.cfg[2:1]);
	// held emergency command suppresses input-sourced faults
	assign fault_in = overload_trip | (di_fault & ~cmd_word0[MIO_CMD_PREP_EMERG]); // R15

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic out2_cmd;
		logic aux_cmd;
		logic in_fault;
		logic [31:0] period;
		out2_cmd = cmd_word0[MIO_CMD_OUT2]; // R17
		aux_cmd = cmd_word0[MIO_CMD_AUX]; // R17
		in_fault = 1'b0;
		period = (store_rdata == 32'h0000_0000) ? 32'(MIO_BLINK_CYC) : store_rdata;
		s_d = s_q;
		ev = '0;

		// ------------------------------------------------------------
		// fault tracker; mode-independent so overload is still evaluated
		// ------------------------------------------------------------
		case (mio_tstate_t'(s_q.tstate)) // R01
			MIO_ST_IDLE: begin
				if (fault_in) begin
					s_d.tstate = MIO_ST_FAULT;
					ev[MIO_EV_FAULT] = 1'b1;
				end
			end
			MIO_ST_FAULT: begin
				if (cmd_word0[MIO_CMD_FAULT_RESET] && !fault_in) begin
					s_d.tstate = MIO_ST_WAIT;
					ev[MIO_EV_CLEAR] = 1'b1;
				end
			end
			MIO_ST_WAIT: begin
				if (!cmd_word0[MIO_CMD_FAULT_RESET]) begin
					s_d.tstate = MIO_ST_IDLE;
				end
			end
			default: s_d.tstate = MIO_ST_IDLE;
		endcase
		in_fault = (mio_tstate_t'(s_d.tstate) == MIO_ST_FAULT);
		s_d.fault = in_fault;

		// ------------------------------------------------------------
		// rising prepare-emergency resets thermal memory when enabled
		// ------------------------------------------------------------
		s_d.prep_prev = cmd_word0[MIO_CMD_PREP_EMERG]; // R17
		s_d.cold_pulse = s_q.cfg[3] & cmd_word0[MIO_CMD_PREP_EMERG] & ~s_q.prep_prev; // R15
		if (s_d.cold_pulse) begin
			ev[MIO_EV_COLD] = 1'b1;
		end
		if (overload_warn) begin
			ev[MIO_EV_WARN] = 1'b1;
		end

		// ------------------------------------------------------------
		// output mapping
		// ------------------------------------------------------------
		// fault-owned outputs override the bus bits
		out2_cmd = owned_bit(fout, MIO_FOUT_OUT2, out2_cmd, in_fault); // R03 R08 R13
		aux_cmd = owned_bit(fout, MIO_FOUT_AUX, aux_cmd, in_fault); // R03 R08 R13

		// relay outputs per control function; no sequencing or checkback
		if (mode == MIO_MODE_PASS) begin
			s_d.relays = {
				aux_cmd,
				out2_cmd,
				cmd_word0[MIO_CMD_OUT1],
				cmd_word0[MIO_CMD_OUT0]
			}; // R02 R04 R05 R17
		end else begin
			s_d.relays = {
				aux_cmd,
				out2_cmd,
				in_fault,
				~in_fault
			}; // R07 R09 R10
		end

		// ------------------------------------------------------------
		// inputs and monitoring image
		// ------------------------------------------------------------
		// inputs registered, then copied into the image one cycle later; no multifunction use
		s_d.di = {
			digital_input_five,
			digital_input_four,
			digital_input_three,
			digital_input_two,
			digital_input_one,
			digital_input_zero
		}; // R02 R06 R07

		// monitoring image in standard allocation
		s_d.mon.word0 = MIO_WORD_RST; // R14
		s_d.mon.word0[MIO_MON_SUM_WARN] = overload_warn; // R16
		s_d.mon.word0[MIO_MON_SUM_FAULT] = in_fault; // R11
		s_d.mon.word0[MIO_MON_OVL_WARN] = overload_warn; // R16
		s_d.mon.word0[MIO_MON_DI_LSB +: 6] = s_q.di; // R16
		s_d.mon.word1 = clamp_pct(motor_current_pct); // R16

		// ------------------------------------------------------------
		// panel blink timer
		// ------------------------------------------------------------
		// toggles every period cycles while faulted, dark otherwise
		if (in_fault) begin
			if (step32(s_q.blink_cnt) >= period) begin
				s_d.blink_cnt = '0;
				s_d.blink = ~s_q.blink;
			end else begin
				s_d.blink_cnt = step32(s_q.blink_cnt);
			end
		end else begin
			s_d.blink_cnt = '0;
			s_d.blink = 1'b0;
		end

		// ------------------------------------------------------------
		// software port
		// ------------------------------------------------------------
		// software writes
		if (reg_wr) begin
			case (reg_addr)
				MIO_REG_CFG: s_d.cfg = reg_wdata[7:0];
				MIO_REG_IRQ_MASK: s_d.irq_mask = reg_wdata[MIO_IRQ_W-1:0];
				default: ;
			endcase
		end

		// sticky status: read clears, new event wins
		if (reg_rd && reg_addr == MIO_REG_IRQ_STAT) begin
			s_d.irq_stat = ev;
		end else begin
			s_d.irq_stat = s_q.irq_stat | ev;
		end

		// live read data
		case (reg_addr)
			MIO_REG_CFG: s_d.rdata = {8'h00, s_q.cfg};
			MIO_REG_STATUS: s_d.rdata = {8'h00, 2'b00, s_q.tstate, s_q.relays};
			MIO_REG_IRQ_STAT: s_d.rdata = {12'h000, s_q.irq_stat};
			MIO_REG_IRQ_MASK: s_d.rdata = {12'h000, s_q.irq_mask};
			default: s_d.rdata = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.cfg <= MIO_CFG_RST;
			s_q.relays <= 4'h1; // R09
			rd_store_q <= 1'b0;
		end else begin
			s_q <= s_d;
			rd_store_q <= reg_rd && reg_addr == MIO_REG_BLINK;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// relay contacts and outputs, all registered
	assign relay_output_zero = s_q.relays[0];
	assign relay_output_one = s_q.relays[1];
	assign relay_output_two = s_q.relays[2];
	assign aux_supply_output = s_q.relays[3];

	// lamps
	assign red_led = s_q.fault; // R12
	assign panel_fault_symbol = s_q.blink; // R12

	// process image and thermal model pulse
	assign mon_image = s_q.mon;
	assign thermal_cold_reset = s_q.cold_pulse;

	// read data one cycle after the strobe, from the store or the live mux
	assign reg_rdata = rd_store_q ? store_rdata : {16'h0000, s_q.rdata};

	// level interrupt from unmasked sticky bits
	assign irq = |(s_q.irq_stat & s_q.irq_mask);
endmodule

// ### mio_pkg.sv
// package for the motor output-control block: process image layout, modes,
// state record and timing constants; no surroundings assumed
package mio_pkg;

	// ----------------------------------------------------------------
	// control functions and fault-output selection
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		MIO_MODE_PASS = 1'b0,
		MIO_MODE_OLR = 1'b1
	} mio_mode_t;

	typedef enum logic [1:0] {
		MIO_FOUT_NONE = 2'b00,
		MIO_FOUT_OUT2 = 2'b01,
		MIO_FOUT_AUX = 2'b10
	} mio_fout_t;

	// ----------------------------------------------------------------
	// monitoring word 0 bit positions (byte 0 high byte, byte 1 low byte)
	// ----------------------------------------------------------------
	localparam int MIO_MON_SUM_WARN = 15;
	localparam int MIO_MON_SUM_FAULT = 14;
	localparam int MIO_MON_OVL_WARN = 11;
	localparam int MIO_MON_DI_LSB = 2;

	// command word 0 bit positions
	localparam int MIO_CMD_FAULT_RESET = 14;
	localparam int MIO_CMD_PREP_EMERG = 12;
	localparam int MIO_CMD_OUT2 = 7;
	localparam int MIO_CMD_OUT1 = 6;
	localparam int MIO_CMD_OUT0 = 5;
	localparam int MIO_CMD_AUX = 4;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] MIO_CURRENT_MAX = 16'h0320; // 800 percent
	localparam logic [15:0] MIO_WORD_RST = 16'h0000;
	localparam int MIO_CLK_MHZ = 50;
	localparam int MIO_BLINK_MS = 250;
	localparam int MIO_BLINK_CYC = MIO_BLINK_MS * 1000 * MIO_CLK_MHZ;
	localparam int MIO_IRQ_W = 4;

	// fieldbus exchange carriers
	typedef struct packed {
		logic [15:0] word0;
		logic [15:0] word1;
	} mio_image_t;

	// interrupt event bits
	localparam int MIO_EV_FAULT = 0;
	localparam int MIO_EV_CLEAR = 1;
	localparam int MIO_EV_WARN = 2;
	localparam int MIO_EV_COLD = 3;

	// software register offsets
	localparam logic [3:0] MIO_REG_CFG = 4'h0;
	localparam logic [3:0] MIO_REG_STATUS = 4'h1;
	localparam logic [3:0] MIO_REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] MIO_REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] MIO_REG_BLINK = 4'h4;

	// config register: [0] mode, [2:1] fault output, [3] emergency enable
	localparam logic [7:0] MIO_CFG_RST = 8'h00;

	typedef struct packed {
		logic [7:0] cfg;
		logic fault;
		logic [1:0] tstate;
		logic prep_prev;
		logic cold_pulse;
		logic [MIO_IRQ_W-1:0] irq_stat;
		logic [MIO_IRQ_W-1:0] irq_mask;
		logic [31:0] blink_cnt;
		logic blink;
		logic [3:0] relays;
		logic [5:0] di;
		logic [15:0] rdata;
		mio_image_t mon;
	} mio_state_t;

	// fault tracker states
	typedef enum logic [1:0] {
		MIO_ST_IDLE = 2'b00,
		MIO_ST_FAULT = 2'b01,
		MIO_ST_WAIT = 2'b10
	} mio_tstate_t;

endpackage

// ### mio_regfile.sv
// small register store for the blink period;
// assumes one write and one read port on the system clock
`timescale 1ns/1ps
module mio_regfile #(
	parameter int DEPTH = 4,
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// write port
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port, data registered
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	// store and registered read
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			rd_data <= '0;
		end else begin
			if (wr_en) begin
				mem_q[wr_addr] <= wr_data;
			end
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule

// ### mio_core_asserts.sv
// checker for the motor output-control core, ports only
// assumes mio_pkg compiled first and one clock domain
`timescale 1ns/1ps
module mio_core_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// process image and thermal side
	input wire logic [15:0] cmd_word0,
	input mio_pkg::mio_image_t mon_image,
	input wire logic overload_warn,
	input wire logic [15:0] motor_current_pct,
	input wire logic thermal_cold_reset,
	// field pins and lamps
	input wire logic digital_input_zero,
	input wire logic digital_input_one,
	input wire logic digital_input_two,
	input wire logic digital_input_three,
	input wire logic digital_input_four,
	input wire logic digital_input_five,
	input wire logic relay_output_zero,
	input wire logic relay_output_one,
	input wire logic red_led,
	input wire logic panel_fault_symbol,
	input wire logic irq
);
	import mio_pkg::*;
	logic [5:0] di_pins;
	logic [15:0] cur_exp;
	// pins gathered in monitoring order, current clamp
	assign di_pins = {digital_input_five, digital_input_four, digital_input_three,
		digital_input_two, digital_input_one, digital_input_zero};
	assign cur_exp = (motor_current_pct > MIO_CURRENT_MAX) ? MIO_CURRENT_MAX : motor_current_pct;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_FLT_MON: assert property (red_led == mon_image.word0[MIO_MON_SUM_FAULT])
		else $error("fault bit and lamp differ");
	AST_RELAY: assert property (relay_output_zero != $past(cmd_word0[MIO_CMD_OUT0]) |->
		relay_output_one == !relay_output_zero && relay_output_one == red_led)
		else $error("relay pair wrong");
	AST_BLINK: assert property ($changed(panel_fault_symbol) |-> $past(red_led))
		else $error("symbol moved without fault");
	AST_WARN: assert property (mon_image.word0[MIO_MON_SUM_WARN] == $past(overload_warn))
		else $error("warning bits differ");
	AST_OVW: assert property (mon_image.word0[MIO_MON_OVL_WARN] == $past(overload_warn))
		else $error("overload warning bit late");
	AST_DI: assert property (mon_image.word0[7:2] == $past(di_pins, 2))
		else $error("input bits wrong");
	AST_CUR: assert property (mon_image.word1 == $past(cur_exp))
		else $error("current word wrong");
	AST_COLD: assert property (thermal_cold_reset |->
		$past(cmd_word0[MIO_CMD_PREP_EMERG]) && !$past(cmd_word0[MIO_CMD_PREP_EMERG], 2))
		else $error("cold reset without rising edge");
	AST_COLD1: assert property (thermal_cold_reset |=> !thermal_cold_reset)
		else $error("cold reset too long");
	// main scenarios reached
	C_FAULT: cover property ($rose(red_led));
	C_COLD: cover property (thermal_cold_reset);
	C_IRQ: cover property ($fell(irq));
endmodule
bind mio_core mio_core_asserts u_chk (.ref_clk, .reset, .cmd_word0, .mon_image, .overload_warn,
	.motor_current_pct, .thermal_cold_reset, .digital_input_zero, .digital_input_one, .digital_input_two,
	.digital_input_three, .digital_input_four, .digital_input_five, .relay_output_zero,
	.relay_output_one, .red_led, .panel_fault_symbol, .irq);

// ### mio_fb_master.sv
// fieldbus master model: drives command word 0 after a clock edge
// assumes the bench calls send from its main thread
`timescale 1ns/1ps
module mio_fb_master (
	// clock
	input wire logic ref_clk,
	// command image
	output logic [15:0] cmd_word0
);
	import mio_pkg::*;
	initial cmd_word0 = MIO_WORD_RST;
	// contactor and start logic live in the master
	task automatic send(input logic [15:0] w);
		@(posedge ref_clk);
		cmd_word0 <= w;
	endtask
endmodule

// ### mio_core_tb.sv
// bench for the motor output-control core: register tasks and scenarios
// assumes package, core, checker and master model compiled first
`timescale 1ns/1ps
module mio_core_tb;
	import mio_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic trip = 1'b0;
	logic warn = 1'b0;
	logic dif = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] cur = 16'h0000;
	logic [5:0] di = 6'h00;
	logic [3:0] ra = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rv, rdat;
	logic [15:0] cmd;
	mio_image_t mon;
	logic thr, r0, r1, r2, aux, led, sym, irq, sv;
	int err_count = 0;
	int n_checks = 0;
	int cnt;
	always #10 ref_clk = ~ref_clk;
	mio_fb_master mst (.ref_clk(ref_clk), .cmd_word0(cmd));
	mio_core dut (.ref_clk(ref_clk), .reset(reset), .cmd_word0(cmd), .mon_image(mon), .overload_trip(trip),
		.overload_warn(warn), .motor_current_pct(cur), .di_fault(dif), .thermal_cold_reset(thr),
		.digital_input_zero(di[0]), .digital_input_one(di[1]), .digital_input_two(di[2]),
		.digital_input_three(di[3]), .digital_input_four(di[4]), .digital_input_five(di[5]),
		.relay_output_zero(r0), .relay_output_one(r1), .relay_output_two(r2), .aux_supply_output(aux),
		.red_led(led), .panel_fault_symbol(sym), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdat), .irq(irq));
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a);
		@(posedge ref_clk);
		rd <= 1'b1;
		ra <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		rv = rdat;
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// watchdog, far beyond the scenario length
	initial begin
		#400000;
		err_count++;
		test_done;
	end
	// scenarios
	initial begin
		repeat (5) @(posedge ref_clk);
		#1;
		chk("rst hold", {r0, r1, r2, aux}, 4'b1000);
		@(posedge ref_clk);
		reset <= 1'b0;
		cyc(2);
		chk("rst relays", {r0, r1, r2, aux}, 4'b0000);
		chk("rst irq", irq, 1'b0);
		rreg(MIO_REG_CFG);
		chk("rst cfg", rv, 32'h0);
		$display("test reset done");
		trip <= 1'b1;
		warn <= 1'b1;
		cur <= 16'h0384;
		di <= 6'h2d;
		for (int i = 4; i < 8; i++) begin
			mst.send(16'h0001 << i);
			cyc(2);
			chk("pass outs", {r2, r1, r0, aux}, 4'b0001 << (i - 4));
		end
		chk("pass di", mon.word0[7:2], 6'h2d);
		chk("pass cur", mon.word1, MIO_CURRENT_MAX);
		chk("pass warn", {mon.word0[15], mon.word0[11]}, 2'b11);
		chk("pass fault", mon.word0[14], 1'b1);
		wreg(MIO_REG_CFG, 32'h2);
		mst.send(16'h0000);
		cyc(2);
		chk("pass fout", r2, 1'b1);
		trip <= 1'b0;
		warn <= 1'b0;
		cur <= 16'h0100;
		mst.send(16'h4000);
		mst.send(16'h0000);
		cyc(2);
		chk("pass clr", {r2, led, mon.word1}, {2'b00, 16'h0100});
		$display("test pass-through done");
		wreg(MIO_REG_CFG, 32'h5);
		wreg(MIO_REG_IRQ_MASK, 32'hffff_fff1);
		wreg(MIO_REG_BLINK, 32'h4);
		mst.send(16'h0090);
		cyc(2);
		chk("olr idle", {r0, r1, r2, aux}, 4'b1010);
		di <= 6'h12;
		cyc(3);
		chk("olr di", {mon.word0[7:2], r0, r1}, {6'h12, 2'b10});
		trip <= 1'b1;
		cyc(2);
		chk("olr fault", {r0, r1, r2, aux}, 4'b0111);
		chk("olr lamp", {led, mon.word0[14], irq}, 3'b111);
		cnt = 0;
		sv = sym;
		repeat (12) begin
			cyc(1);
			if (sym !== sv) cnt++;
			sv = sym;
		end
		chk("blink", cnt, 3);
		rreg(MIO_REG_IRQ_STAT);
		chk("stat fault", rv[MIO_EV_FAULT], 1'b1);
		cyc(1);
		chk("irq read clr", irq, 1'b0);
		wreg(MIO_REG_IRQ_MASK, 32'h0);
		trip <= 1'b0;
		mst.send(16'h4000);
		mst.send(16'h0000);
		cyc(2);
		chk("olr clear", {r0, r1, r2, aux, led, irq}, 6'b100000);
		wreg(MIO_REG_IRQ_MASK, 32'h2);
		cyc(1);
		chk("irq unmask", irq, 1'b1);
		rreg(MIO_REG_IRQ_STAT);
		chk("stat clr", rv[MIO_EV_CLEAR], 1'b1);
		cyc(1);
		chk("irq off", irq, 1'b0);
		$display("test overload relay done");
		wreg(MIO_REG_CFG, 32'h9);
		mst.send(16'h1000);
		cnt = 0;
		repeat (6) begin
			cyc(1);
			if (thr === 1'b1) cnt++;
		end
		chk("cold pulse", cnt, 1);
		dif <= 1'b1;
		cyc(3);
		chk("di suppressed", led, 1'b0);
		mst.send(16'h0000);
		cyc(3);
		chk("di fault", led, 1'b1);
		wreg(4'h9, 32'hff);
		rreg(4'h9);
		chk("unmapped", rv, 32'h0);
		rreg(MIO_REG_BLINK);
		chk("blink reg", rv, 32'h4);
		$display("test emergency done");
		test_done;
	end
endmodule
